// ===== verif/esc_chan_model.sv
// Behavioural channel cores: interrupt lines and once-a-second pulses
`timescale 1ns/1ps
module esc_chan_model #(
  parameter int SECOND = 8 // Cycles per counter second, shortened
) (
  input wire logic clock, // Counter source clock
  input wire logic [1:0] run, // Channel clocked and out of reset
  input wire esc_pkg::esc_irq_s ev0, // Events commanded on ch0
  input wire esc_pkg::esc_irq_s ev1, // Events commanded on ch1
  output esc_pkg::esc_irq_s ch0_irq = '0, // Ch0 lines
  output esc_pkg::esc_irq_s ch1_irq = '0, // Ch1 lines
  output logic [1:0] pulse = 2'h0 // Pulses
);
  int cnt [2] = '{0, 0}; // Ticks per channel
  // Lines move just after the falling edge; a stopped channel never pulses
  always @(negedge clock) begin
    for (int c = 0; c < 2; c++) begin
      cnt[c] = run[c] ? (cnt[c] + 1) % SECOND : 0;
      pulse[c] <= run[c] && cnt[c] == SECOND - 1;
    end
    ch0_irq <= ev0;
    ch1_irq <= ev1;
  end
endmodule : esc_chan_model

// ===== verif/esc_sva.sv
// Port checker for the system control block
`timescale 1ns/1ps
module esc_sva (
  input wire logic clock, // Bus clock
  input wire logic rst, // Sync reset
  input wire esc_pkg::esc_req_s req, // Access request
  input wire logic [31:0] rdata, // Read data
  input wire logic ack, // Acknowledge
  input wire esc_pkg::esc_irq_s ch0_irq, // Ch0 lines in
  input wire esc_pkg::esc_irq_s ch1_irq, // Ch1 lines in
  input wire logic ch0_pulse, // Ch0 pulse
  input wire logic ch1_pulse, // Ch1 pulse
  input wire logic shared_pulse_pin, // Pulse pin
  input wire logic channel0_hw_reset, // Reset 0
  input wire logic channel1_hw_reset, // Reset 1
  input wire logic phy_interface_select, // Mode
  input wire logic channel0_clock_enable, // Gate 0
  input wire logic channel1_clock_enable, // Gate 1
  input wire logic ch0_dma_done_irq, // Irq out
  input wire logic ch0_wakeup_irq, // Irq out
  input wire logic ch0_low_power_exit_irq, // Irq out
  input wire logic ch1_dma_done_irq, // Irq out
  input wire logic ch1_wakeup_irq // Irq out
);
  logic [31:0] mode, clkg, next_mode, next_clkg, rexp; // Shadow of stored fields
  logic take; // Request taken at this edge
  assign take = req.sel && !ack;
  assign rexp = (req.addr == 8'h00) ? mode : (req.addr == 8'h08) ? clkg : 32'h0000_0000;
  // Shadow keeps only writable bits, so reserved bits are expected as zero
  always_comb begin
    next_mode = mode;
    next_clkg = clkg;
    if (take && req.wr && req.addr == 8'h00) next_mode = req.wdata & 32'h1000_0301;
    if (take && req.wr && req.addr == 8'h08) next_clkg = req.wdata & 32'h0000_0003;
  end
  // Shadow registers
  always_ff @(posedge clock) begin
    mode <= rst ? 32'h0000_0000 : next_mode;
    clkg <= rst ? 32'h0000_0000 : next_clkg;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take; take; endsequence
  sequence s_answer; ack ##1 !ack; endsequence
  property p_ack; s_take |=> s_answer; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_rd; take && !req.wr |=> rdata == $past(rexp); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_dma; !$past(rst) |-> ch0_dma_done_irq == $past(ch0_irq.dma_done)
    && ch1_dma_done_irq == $past(ch1_irq.dma_done); endproperty
  a_dma: assert property (p_dma) else $error("dma irq wrong");
  property p_wake; !$past(rst) |-> ch0_wakeup_irq == $past(ch0_irq.wakeup)
    && ch1_wakeup_irq == $past(ch1_irq.wakeup); endproperty
  a_wake: assert property (p_wake) else $error("wakeup irq wrong");
  property p_lpi; !$past(rst) |-> ch0_low_power_exit_irq == $past(ch0_irq.low_power_exit);
  endproperty
  a_lpi: assert property (p_lpi) else $error("low power irq wrong");
  property p_pin; !$past(rst) |-> shared_pulse_pin == $past(mode[28] ? ch1_pulse : ch0_pulse);
  endproperty
  a_pin: assert property (p_pin) else $error("pulse pin wrong");
  property p_rst; channel0_hw_reset == $past(mode[8])
    && channel1_hw_reset == $past(mode[9]); endproperty
  a_rst: assert property (p_rst) else $error("channel reset wrong");
  property p_ifs; phy_interface_select == $past(mode[0]); endproperty
  a_ifs: assert property (p_ifs) else $error("interface select wrong");
  property p_gate; channel0_clock_enable == $past(clkg[0])
    && channel1_clock_enable == ($past(clkg[1:0]) == 2'h3); endproperty
  a_gate: assert property (p_gate) else $error("clock gate wrong");
endmodule : esc_sva

// ===== verif/esc_top_tb_top.sv
// Self-checking bench for the system control block
`timescale 1ns/1ps
module esc_top_tb_top;
  localparam int SEC = 8; // Shortened counter second
  logic clock = 1'b0; // Bus clock
  logic rst = 1'b1; // Sync reset
  esc_pkg::esc_req_s req = '0; // Access request
  esc_pkg::esc_irq_s ev0 = '0; // Events on ch0
  esc_pkg::esc_irq_s ev1 = '0; // Events on ch1
  esc_pkg::esc_irq_s ch0_irq, ch1_irq; // Model lines
  logic [1:0] pulse; // Model pulses
  logic [31:0] rdata; // Read data
  logic ack, pin, hwr0, hwr1, ifs, en0, en1; // Outputs
  wire [4:0] irq; // Interrupt outputs
  int num_errors = 0; // Mismatches
  int samples_checked = 0; // Comparisons
`define CHK(n, g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
  esc_top dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .ack(ack),
    .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .ch0_pulse(pulse[0]), .ch1_pulse(pulse[1]),
    .shared_pulse_pin(pin), .channel0_hw_reset(hwr0), .channel1_hw_reset(hwr1),
    .phy_interface_select(ifs), .channel0_clock_enable(en0), .channel1_clock_enable(en1),
    .ch0_dma_done_irq(irq[4]), .ch0_wakeup_irq(irq[3]), .ch0_low_power_exit_irq(irq[2]),
    .ch1_dma_done_irq(irq[1]), .ch1_wakeup_irq(irq[0]));
  esc_chan_model #(.SECOND(SEC)) chans (.clock(clock), .run({en1 & ~hwr1, en0 & ~hwr0}),
    .ev0(ev0), .ev1(ev1), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .pulse(pulse));
  // Clock
  initial forever #20 clock = ~clock;
  // One access; sel dropped in the ack cycle, then one idle cycle
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    req = '{1'b1, w, a, d};
    @(negedge clock);
    `CHK("ack", ack, 1'b1)
    if (!w) `CHK("rdata", rdata, d)
    req.sel = 1'b0;
    @(negedge clock);
  endtask : xfer
  // Counts pin pulses over three counter seconds
  task automatic count_pin(input int exp);
    int n;
    n = 0;
    repeat (3 * SEC) begin
      @(negedge clock);
      n += int'(pin);
    end
    `CHK("pulses", n, exp)
  endtask : count_pin
  // Software bring-up: gate clocks, raise resets, wait for PHY clock, release
  task automatic bring_up(input logic [1:0] g, input logic [31:0] m, input logic [4:0] e);
    xfer(8'h08, 1'b1, 32'(g));
    xfer(8'h00, 1'b1, m);
    repeat (4) @(negedge clock);
    `CHK("held", {hwr1, hwr0, ifs, en1, en0}, e)
    xfer(8'h00, 1'b1, m & 32'h0000_0001);
    `CHK("released", {hwr1, hwr0, ifs, en1, en0}, e & 5'h07)
  endtask : bring_up
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard, well past the expected run
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK("outs", {hwr1, hwr0, ifs, en1, en0, pin}, 6'h00)
    xfer(8'h00, 1'b0, 32'h0000_0000);
    xfer(8'h08, 1'b0, 32'h0000_0000);
    xfer(8'h04, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h04, 1'b0, 32'h0000_0000);
    xfer(8'h00, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h00, 1'b0, 32'h1000_0301);
    `CHK("mode", {hwr1, hwr0, ifs}, 3'h7)
    for (int v = 0; v < 4; v++) begin
      xfer(8'h08, 1'b1, 32'hFFFF_FFFC | v);
      xfer(8'h08, 1'b0, 32'(v));
      `CHK("gates", {en1, en0}, (v == 3) ? 2'h3 : (v == 1) ? 2'h1 : 2'h0)
    end
    xfer(8'h00, 1'b1, 32'h1000_0200);
    count_pin(0);
    xfer(8'h00, 1'b1, 32'h0000_0200);
    count_pin(3);
    xfer(8'h00, 1'b1, 32'h1000_0000);
    count_pin(3);
    for (int i = 0; i < 8; i++) begin
      ev0 = 3'(i);
      ev1 = 3'(7 - i);
      repeat (3) @(negedge clock);
      `CHK("irq", irq, {ev0, ev1.dma_done, ev1.wakeup})
    end
    // Reset in mid-run must bring every field back to zero
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    `CHK("outs2", {hwr1, hwr0, ifs, en1, en0, pin}, 6'h00)
    xfer(8'h00, 1'b0, 32'h0000_0000);
    xfer(8'h08, 1'b0, 32'h0000_0000);
    // Bring-up sequences in the order software runs them
    bring_up(2'h1, 32'h0000_0100, 5'h09);
    bring_up(2'h1, 32'h0000_0101, 5'h0D);
    bring_up(2'h3, 32'h0000_0301, 5'h1F);
    wrap_up();
  end
endmodule : esc_top_tb_top
bind esc_top esc_sva u_sva (.*);

// ===== verilog/esc_cfg.svh
// Offsets, field positions and reset values of the system control registers
`ifndef ESC_CFG_SVH
`define ESC_CFG_SVH
`define ESC_OFS_MODE 8'h00
`define ESC_OFS_CLKG 8'h08
`define ESC_BIT_IFSEL 0
`define ESC_BIT_HWR0 8
`define ESC_BIT_HWR1 9
`define ESC_BIT_PULSE 28
`define ESC_CLKG_LO 0
`define ESC_CLKG_HI 1
`define ESC_CLKG_OFF 2'h0
`define ESC_CLKG_CH0 2'h1
`define ESC_CLKG_BAD 2'h2
`define ESC_CLKG_BOTH 2'h3
`define ESC_ZERO32 32'h0000_0000
`define ESC_BUS_MIN_MHZ 25
`endif

// ===== verilog/esc_pkg.sv
// Types shared by the system control block
package esc_pkg;
  // Per-channel interrupt lines from a channel core
  typedef struct packed {
    logic dma_done;
    logic wakeup;
    logic low_power_exit;
  } esc_irq_s;
  // Register access request
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } esc_req_s;
  // Write decode states
  typedef enum logic [1:0] {
    ESC_IDLE = 2'b01,
    ESC_WRITE = 2'b10
  } esc_state_e;
endpackage : esc_pkg

// ===== verilog/esc_rdreg.sv
// Registered read-data holder for the register bank
`timescale 1ns/1ps
module esc_rdreg #(
  parameter int WIDTH = 32 // Data width
) (
  input wire logic clock, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic load, // Capture strobe
  input wire logic [WIDTH-1:0] din, // Value to capture
  output logic [WIDTH-1:0] dout // Registered value
);
  logic [WIDTH-1:0] next_dout; // Next held value

  // Hold old value until a new read is taken
  always_comb begin
    next_dout = load ? din : dout;
  end

  // Register only
  always_ff @(posedge clock) begin
    if (rst) begin
      dout <= '0;
    end else begin
      dout <= next_dout;
    end
  end
endmodule : esc_rdreg

// ===== verilog/esc_top.sv
// Ethernet system control register bank and channel glue
// What this block does
// - Bus clock feeds each channel's time counter.
// - Each channel routes DMA-done interrupt out.
// - Each channel routes wake-up interrupt out.
// - Channel 0 routes low-power-exit interrupt out.
// - Channel 1 has no low-power interrupt.
// - Pulse select bit picks channel pulse output.
// - Channel 1 reset bit drives its reset.
// - Channel 0 reset bit drives its reset.
// - Interface bit selects MII or RMII.
// - Reserved mode bits read zero.
// - Mode at 0x00, clock gating at 0x08.
// - Clock field 00 off, 01 ch0, 11 both.
// - Each channel pulses once per counter second.
`timescale 1ns/1ps
`include "esc_cfg.svh"
module esc_top (
  input wire logic clock, // Bus clock, also time counter source
  input wire logic rst, // Sync reset, active high
  input wire esc_pkg::esc_req_s req, // Register access request
  output logic [31:0] rdata, // Registered read data
  output logic ack, // One-cycle access acknowledge
  input wire esc_pkg::esc_irq_s ch0_irq, // Channel 0 interrupt lines
  input wire esc_pkg::esc_irq_s ch1_irq, // Channel 1 interrupt lines
  input wire logic ch0_pulse, // Channel 0 once-a-second pulse
  input wire logic ch1_pulse, // Channel 1 once-a-second pulse
  output logic shared_pulse_pin, // Selected pulse to the pin
  output logic channel0_hw_reset, // Hardware reset to channel 0
  output logic channel1_hw_reset, // Hardware reset to channel 1
  output logic phy_interface_select, // 0 MII, 1 RMII to pin mux
  output logic channel0_clock_enable, // Clock gate for channel 0
  output logic channel1_clock_enable, // Clock gate for channel 1
  output logic ch0_dma_done_irq, // To interrupt controller
  output logic ch0_wakeup_irq, // To interrupt controller
  output logic ch0_low_power_exit_irq, // To interrupt controller
  output logic ch1_dma_done_irq, // To interrupt controller
  output logic ch1_wakeup_irq // To interrupt controller
);
  // The time counter source is the bus clock itself, so the channels
  // take clock directly; no gating or division happens here.

  // Control state
  logic time_pulse_channel_select; // Pulse source select
  logic channel0_hw_reset_ctl; // Stored ch0 reset bit
  logic channel1_hw_reset_ctl; // Stored ch1 reset bit
  logic phy_if_sel; // Stored interface bit
  logic [1:0] channel_clock_enable_field; // Stored clock gating field
  logic next_pulse_sel; // Next pulse select
  logic next_reset0; // Next ch0 reset
  logic next_reset1; // Next ch1 reset
  logic next_ifsel; // Next interface bit
  logic [1:0] next_clkg; // Next clock gating
  esc_pkg::esc_state_e state; // Access phase
  esc_pkg::esc_state_e next_state; // Next access phase
  logic next_ack; // Next acknowledge
  logic [31:0] read_mux; // Combinational read value
  logic hit_mode; // Mode register addressed
  logic hit_clkg; // Clock gating register addressed

  // Offset compare used for both registers
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Address decode
  // Only the low byte of the offset reaches this block; the base address
  // is matched before the request arrives. Unmapped offsets still get an
  // acknowledge so that a stray access never stalls the bus.
  always_comb begin
    hit_mode = addr_hit(req.addr, `ESC_OFS_MODE);
    hit_clkg = addr_hit(req.addr, `ESC_OFS_CLKG);
  end

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    read_mux = `ESC_ZERO32;
    if (hit_mode) begin
      read_mux[`ESC_BIT_PULSE] = time_pulse_channel_select;
      read_mux[`ESC_BIT_HWR1] = channel1_hw_reset_ctl;
      read_mux[`ESC_BIT_HWR0] = channel0_hw_reset_ctl;
      read_mux[`ESC_BIT_IFSEL] = phy_if_sel;
    end else if (hit_clkg) begin
      read_mux[`ESC_CLKG_HI:`ESC_CLKG_LO] = channel_clock_enable_field;
    end
  end

  // Access phase: idle takes a request, write phase acknowledges it
  // A request held past its acknowledge would be taken again, so the
  // master drops select in the cycle that shows the acknowledge.
  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    case (state)
      esc_pkg::ESC_IDLE: begin
        if (req.sel) begin
          next_state = esc_pkg::ESC_WRITE;
          next_ack = 1'b1;
        end
      end
      esc_pkg::ESC_WRITE: begin
        // One idle cycle between accesses keeps the ack a clean pulse
        next_state = esc_pkg::ESC_IDLE;
      end
      default: begin
        next_state = esc_pkg::ESC_IDLE;
      end
    endcase
  end

  // Register writes; only the writable fields are stored
  // Reserved bits of a written word are dropped here rather than stored,
  // which is why they can only ever read back as zero.
  // Software is expected to gate clocks first, then raise the channel
  // resets, and release them only once the PHY side clock is running;
  // the block does not enforce that order, it just stores what it is told.
  always_comb begin
    next_pulse_sel = time_pulse_channel_select;
    next_reset0 = channel0_hw_reset_ctl;
    next_reset1 = channel1_hw_reset_ctl;
    next_ifsel = phy_if_sel;
    next_clkg = channel_clock_enable_field;
    if (state == esc_pkg::ESC_IDLE && req.sel && req.wr) begin
      if (hit_mode) begin
        next_pulse_sel = req.wdata[`ESC_BIT_PULSE];
        next_reset1 = req.wdata[`ESC_BIT_HWR1];
        next_reset0 = req.wdata[`ESC_BIT_HWR0];
        next_ifsel = req.wdata[`ESC_BIT_IFSEL];
      end else if (hit_clkg) begin
        // Prohibited 10 is stored as written; software must avoid it
        next_clkg = req.wdata[`ESC_CLKG_HI:`ESC_CLKG_LO];
      end
    end
  end

  // Control and phase registers
  // Every field returns to zero and the phase to idle on reset: clocks to both channels stopped,
  // channel resets released and the MII pin mapping selected.
  always_ff @(posedge clock) begin
    if (rst) begin
      time_pulse_channel_select <= 1'b0;
      channel0_hw_reset_ctl <= 1'b0;
      channel1_hw_reset_ctl <= 1'b0;
      phy_if_sel <= 1'b0;
      channel_clock_enable_field <= `ESC_CLKG_OFF;
      state <= esc_pkg::ESC_IDLE;
      ack <= 1'b0;
    end else begin
      time_pulse_channel_select <= next_pulse_sel;
      channel0_hw_reset_ctl <= next_reset0;
      channel1_hw_reset_ctl <= next_reset1;
      phy_if_sel <= next_ifsel;
      channel_clock_enable_field <= next_clkg;
      state <= next_state;
      ack <= next_ack;
    end
  end

  // Read data captured on the accepting edge
  esc_rdreg #(
    .WIDTH(32)
  ) u_rdreg (
    .clock(clock),
    .rst(rst),
    .load(state == esc_pkg::ESC_IDLE && req.sel && !req.wr),
    .din(read_mux),
    .dout(rdata)
  );

  // Outputs registered from stored state and channel lines; one cycle of delay
  logic next_pulse_out; // Selected pulse
  logic next_clk0; // Channel 0 clock enable
  logic next_clk1; // Channel 1 clock enable
  always_comb begin
    next_pulse_out = time_pulse_channel_select ? ch1_pulse : ch0_pulse;
    // Only 11 clocks channel 1; 10 is treated as off for both
    next_clk0 = (channel_clock_enable_field == `ESC_CLKG_CH0) ||
                (channel_clock_enable_field == `ESC_CLKG_BOTH);
    next_clk1 = (channel_clock_enable_field == `ESC_CLKG_BOTH);
  end

  // Output flops
  // Every pin of the block leaves a flop, so a channel sees its reset,
  // clock gate and mode one cycle after the register write lands.
  // The interrupt lines pass with the same single cycle of delay; they
  // are levels, so the controller sees them as long as the channel holds
  // them and no sticky state is kept here.
  always_ff @(posedge clock) begin
    if (rst) begin
      shared_pulse_pin <= 1'b0;
      channel0_hw_reset <= 1'b0;
      channel1_hw_reset <= 1'b0;
      phy_interface_select <= 1'b0;
      channel0_clock_enable <= 1'b0;
      channel1_clock_enable <= 1'b0;
      ch0_dma_done_irq <= 1'b0;
      ch0_wakeup_irq <= 1'b0;
      ch0_low_power_exit_irq <= 1'b0;
      ch1_dma_done_irq <= 1'b0;
      ch1_wakeup_irq <= 1'b0;
    end else begin
      shared_pulse_pin <= next_pulse_out;
      channel0_hw_reset <= channel0_hw_reset_ctl;
      channel1_hw_reset <= channel1_hw_reset_ctl;
      phy_interface_select <= phy_if_sel;
      channel0_clock_enable <= next_clk0;
      channel1_clock_enable <= next_clk1;
      ch0_dma_done_irq <= ch0_irq.dma_done;
      ch0_wakeup_irq <= ch0_irq.wakeup;
      ch0_low_power_exit_irq <= ch0_irq.low_power_exit;
      ch1_dma_done_irq <= ch1_irq.dma_done;
      ch1_wakeup_irq <= ch1_irq.wakeup;
      // Channel 1 low_power_exit input is ignored: RMII only
    end
  end
endmodule : esc_top
